// *** gtm_far_side.sv ***
// far-side model: debugger halt and first timer datapath raw outputs
`timescale 1ns/10ps
module gtm_far_side
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic haltReq,
  input wire logic pwmReq,
  input wire logic trigReq,
  output logic debugHalt,
  output logic firstPwmRaw,
  output logic firstAdcTriggerRaw
);
  // launched on the falling edge, off the core's sampling edge
  always @(negedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      debugHalt <= 1'b0;
      firstPwmRaw <= 1'b0;
      firstAdcTriggerRaw <= 1'b0;
    end
    else
    begin
      debugHalt <= haltReq;
      firstPwmRaw <= pwmReq;
      firstAdcTriggerRaw <= trigReq; // adc enable and source select assumed set here
    end
  end
endmodule

// *** gtm_pkg.sv ***
// package: register map, field positions and types for timer mode/control block
//
// Functional notes
// [R1] second mode field: 1 one-shot, 2 periodic, 3 capture; 0 reserved.
// [R2] in split halves config, second mode field alone sets second half mode.
// [R3] in wide config, second mode is ignored; first mode field is used.
// [R4] control bits 11:10 pick second capture edge: 0 rise, 1 fall, 3 both.
// [R5] control bits 3:2 pick first capture edge with the same encoding.
// [R6] control bit 9 freezes second timer during debug halt.
// [R7] control bit 1 freezes first timer during debug halt.
// [R8] freeze bits do nothing while the processor runs normally.
// [R9] control bit 8 enables the second timer.
// [R10] control bit 0 enables the first timer.
// [R11] control bit 6 inverts the first timer PWM output.
// [R12] control bit 5 gates the first timer trigger toward the ADC.
// [R13] ADC must be enabled and select this timer to use the trigger.
// [R14] control bit 4 enables real-time-clock counting.
// [R15] software keeps reserved bits across read-modify-write, relies on none.
// [R16] config field: 0 wide, 1 rtc, 4 to 7 split halves.
// [R17] second capture sub-mode bit: 0 edge-count, 1 edge-time.
// [R18] all control and mode fields reset to zero.
package gtm_pkg;
  localparam logic [11:0] ADDR_CONFIG = 12'h0000;
  localparam logic [11:0] ADDR_FIRST_MODE = 12'h0004;
  localparam logic [11:0] ADDR_SECOND_MODE = 12'h0008;
  localparam logic [11:0] ADDR_CONTROL = 12'h000c;
  localparam logic [31:0] RESET_VALUE = 32'h0000_0000;
  localparam logic [31:0] CONFIG_MASK = 32'h0000_0007;
  localparam logic [31:0] MODE_MASK = 32'h0000_000f;
  localparam logic [31:0] CONTROL_MASK = 32'h0000_0f7f;
  localparam int CTL_FIRST_ON = 0;
  localparam int CTL_FIRST_FREEZE = 1;
  localparam int CTL_FIRST_EDGE_LO = 2;
  localparam int CTL_RTC_ON = 4;
  localparam int CTL_FIRST_ADC = 5;
  localparam int CTL_FIRST_INV = 6;
  localparam int CTL_SECOND_ON = 8;
  localparam int CTL_SECOND_FREEZE = 9;
  localparam int CTL_SECOND_EDGE_LO = 10;
  localparam int MODE_SUBMODE = 2;
  localparam int MODE_ALT = 3;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0]
  {
    GTM_MODE_NONE = 2'b00,
    GTM_MODE_ONESHOT = 2'b01,
    GTM_MODE_PERIODIC = 2'b10,
    GTM_MODE_CAPTURE = 2'b11
  } gtm_mode_t;

  typedef enum logic [1:0]
  {
    GTM_EDGE_RISE = 2'b00,
    GTM_EDGE_FALL = 2'b01,
    GTM_EDGE_RSVD = 2'b10,
    GTM_EDGE_BOTH = 2'b11
  } gtm_edge_t;

  typedef enum logic [1:0]
  {
    GTM_CFG_WIDE = 2'b00,
    GTM_CFG_RTC = 2'b01,
    GTM_CFG_SPLIT = 2'b10,
    GTM_CFG_RSVD = 2'b11
  } gtm_cfg_t;

  // decoded per-half controls toward the counting datapaths
  typedef struct packed
  {
    logic run;
    logic advance;
    gtm_mode_t mode;
    logic edgeTime;
    logic pwmSelect;
    logic riseEdge;
    logic fallEdge;
  } gtm_half_t;
endpackage

// *** gtm_timer_mode_control.sv ***
// timer mode and control registers with AXI4-Lite slave and decode
`timescale 1ns/10ps
module gtm_timer_mode_control
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic debugHalt,
  input wire logic firstPwmRaw,
  input wire logic firstAdcTriggerRaw,
  output gtm_pkg::gtm_half_t firstCtl,
  output gtm_pkg::gtm_half_t secondCtl,
  output gtm_pkg::gtm_cfg_t widthConfig,
  output logic rtcCountOn,
  output logic firstPwmOut,
  output logic firstAdcTrigger
);
  logic [31:0] cfgReg, firstModeReg, secondModeReg, controlReg;
  logic [31:0] next_cfgReg, next_firstModeReg, next_secondModeReg, next_controlReg;
  logic [11:0] awAddr, next_awAddr;
  logic awHeld, next_awHeld;
  logic [31:0] wData, next_wData;
  logic [3:0] wStrb, next_wStrb;
  logic wHeld, next_wHeld;
  logic bValid, next_bValid;
  logic [1:0] bResp, next_bResp;
  logic rValid, next_rValid;
  logic [1:0] rResp, next_rResp;
  logic [31:0] rData, next_rData;
  logic haltSync1, haltSync2;
  logic halted;
  logic doWrite;
  logic [31:0] byteMask;
  gtm_pkg::gtm_cfg_t next_widthConfig;
  gtm_pkg::gtm_half_t next_firstCtl, next_secondCtl;
  logic next_pwm, next_trig, next_rtc;

  // debug halt crosses from the core's halt logic
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      haltSync1 <= 1'b0;
      haltSync2 <= 1'b0;
    end
    else
    begin
      haltSync1 <= debugHalt;
      haltSync2 <= haltSync1;
    end
  end
  assign halted = haltSync2;

  assign s_axi_awready = !awHeld && !bValid;
  assign s_axi_wready = !wHeld && !bValid;
  assign s_axi_bvalid = bValid;
  assign s_axi_bresp = bResp;
  assign s_axi_arready = !rValid;
  assign s_axi_rvalid = rValid;
  assign s_axi_rresp = rResp;
  assign s_axi_rdata = rData;
  assign doWrite = awHeld && wHeld && !bValid;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_lane
      assign byteMask[gi*8 +: 8] = {8{wStrb[gi]}};
    end
  endgenerate

  // bus channels and register storage
  always_comb
  begin
    next_awAddr = awAddr;
    next_awHeld = awHeld;
    next_wData = wData;
    next_wStrb = wStrb;
    next_wHeld = wHeld;
    next_bValid = bValid;
    next_bResp = bResp;
    next_rValid = rValid;
    next_rResp = rResp;
    next_rData = rData;
    next_cfgReg = cfgReg;
    next_firstModeReg = firstModeReg;
    next_secondModeReg = secondModeReg;
    next_controlReg = controlReg;
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_awAddr = s_axi_awaddr;
      next_awHeld = 1'b1;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_wData = s_axi_wdata;
      next_wStrb = s_axi_wstrb;
      next_wHeld = 1'b1;
    end
    if (doWrite)
    begin
      next_awHeld = 1'b0;
      next_wHeld = 1'b0;
      next_bValid = 1'b1;
      next_bResp = gtm_pkg::RESP_OKAY;
      case ({awAddr[11:2], 2'b00})
        gtm_pkg::ADDR_CONFIG:
          next_cfgReg = ((cfgReg & ~byteMask) | (wData & byteMask)) & gtm_pkg::CONFIG_MASK;
        gtm_pkg::ADDR_FIRST_MODE:
          next_firstModeReg = ((firstModeReg & ~byteMask) | (wData & byteMask))
            & gtm_pkg::MODE_MASK;
        gtm_pkg::ADDR_SECOND_MODE:
          next_secondModeReg = ((secondModeReg & ~byteMask) | (wData & byteMask))
            & gtm_pkg::MODE_MASK;
        gtm_pkg::ADDR_CONTROL:
          next_controlReg = ((controlReg & ~byteMask) | (wData & byteMask))
            & gtm_pkg::CONTROL_MASK;
        default:
          next_bResp = gtm_pkg::RESP_SLVERR;
      endcase
    end
    else if (bValid && s_axi_bready)
    begin
      next_bValid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready)
    begin
      next_rValid = 1'b1;
      next_rResp = gtm_pkg::RESP_OKAY;
      case ({s_axi_araddr[11:2], 2'b00})
        gtm_pkg::ADDR_CONFIG: next_rData = cfgReg;
        gtm_pkg::ADDR_FIRST_MODE: next_rData = firstModeReg;
        gtm_pkg::ADDR_SECOND_MODE: next_rData = secondModeReg;
        gtm_pkg::ADDR_CONTROL: next_rData = controlReg;
        default:
        begin
          next_rData = gtm_pkg::RESET_VALUE;
          next_rResp = gtm_pkg::RESP_SLVERR;
        end
      endcase
    end
    else if (rValid && s_axi_rready)
    begin
      next_rValid = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      awAddr <= 12'h000;
      awHeld <= 1'b0;
      wData <= gtm_pkg::RESET_VALUE;
      wStrb <= 4'h0;
      wHeld <= 1'b0;
      bValid <= 1'b0;
      bResp <= gtm_pkg::RESP_OKAY;
      rValid <= 1'b0;
      rResp <= gtm_pkg::RESP_OKAY;
      rData <= gtm_pkg::RESET_VALUE;
      cfgReg <= gtm_pkg::RESET_VALUE; // [R18]
      firstModeReg <= gtm_pkg::RESET_VALUE; // [R18]
      secondModeReg <= gtm_pkg::RESET_VALUE; // [R18]
      controlReg <= gtm_pkg::RESET_VALUE; // [R18]
    end
    else
    begin
      awAddr <= next_awAddr;
      awHeld <= next_awHeld;
      wData <= next_wData;
      wStrb <= next_wStrb;
      wHeld <= next_wHeld;
      bValid <= next_bValid;
      bResp <= next_bResp;
      rValid <= next_rValid;
      rResp <= next_rResp;
      rData <= next_rData;
      cfgReg <= next_cfgReg;
      firstModeReg <= next_firstModeReg;
      secondModeReg <= next_secondModeReg;
      controlReg <= next_controlReg;
    end
  end

  // decode of configuration into per-half controls
  always_comb
  begin
    case (cfgReg[2:0])
      3'h0: next_widthConfig = gtm_pkg::GTM_CFG_WIDE; // [R16]
      3'h1: next_widthConfig = gtm_pkg::GTM_CFG_RTC; // [R16]
      3'h4, 3'h5, 3'h6, 3'h7: next_widthConfig = gtm_pkg::GTM_CFG_SPLIT; // [R16]
      default: next_widthConfig = gtm_pkg::GTM_CFG_RSVD;
    endcase
    next_firstCtl.run = controlReg[gtm_pkg::CTL_FIRST_ON]; // [R10]
    next_firstCtl.advance = controlReg[gtm_pkg::CTL_FIRST_ON]
      && !(halted && controlReg[gtm_pkg::CTL_FIRST_FREEZE]); // [R7] [R8]
    next_firstCtl.mode = gtm_pkg::gtm_mode_t'(firstModeReg[1:0]);
    next_firstCtl.edgeTime = firstModeReg[gtm_pkg::MODE_SUBMODE];
    next_firstCtl.pwmSelect = firstModeReg[gtm_pkg::MODE_ALT];
    next_firstCtl.riseEdge = controlReg[gtm_pkg::CTL_FIRST_EDGE_LO +: 2] == 2'b00
      || controlReg[gtm_pkg::CTL_FIRST_EDGE_LO +: 2] == 2'b11; // [R5]
    next_firstCtl.fallEdge = controlReg[gtm_pkg::CTL_FIRST_EDGE_LO] == 1'b1; // [R5]
    next_secondCtl.run = controlReg[gtm_pkg::CTL_SECOND_ON]; // [R9]
    next_secondCtl.advance = controlReg[gtm_pkg::CTL_SECOND_ON]
      && !(halted && controlReg[gtm_pkg::CTL_SECOND_FREEZE]); // [R6] [R8]
    if (next_widthConfig == gtm_pkg::GTM_CFG_SPLIT)
    begin
      next_secondCtl.mode = gtm_pkg::gtm_mode_t'(secondModeReg[1:0]); // [R1] [R2]
      next_secondCtl.edgeTime = secondModeReg[gtm_pkg::MODE_SUBMODE]; // [R17]
      next_secondCtl.pwmSelect = secondModeReg[gtm_pkg::MODE_ALT];
    end
    else
    begin
      next_secondCtl.mode = gtm_pkg::gtm_mode_t'(firstModeReg[1:0]); // [R3]
      next_secondCtl.edgeTime = firstModeReg[gtm_pkg::MODE_SUBMODE]; // [R3]
      next_secondCtl.pwmSelect = firstModeReg[gtm_pkg::MODE_ALT]; // [R3]
    end
    next_secondCtl.riseEdge = controlReg[gtm_pkg::CTL_SECOND_EDGE_LO +: 2] == 2'b00
      || controlReg[gtm_pkg::CTL_SECOND_EDGE_LO +: 2] == 2'b11; // [R4]
    next_secondCtl.fallEdge = controlReg[gtm_pkg::CTL_SECOND_EDGE_LO] == 1'b1; // [R4]
    next_pwm = firstPwmRaw ^ controlReg[gtm_pkg::CTL_FIRST_INV]; // [R11]
    next_trig = firstAdcTriggerRaw && controlReg[gtm_pkg::CTL_FIRST_ADC]; // [R12]
    next_rtc = controlReg[gtm_pkg::CTL_RTC_ON]; // [R14]
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      widthConfig <= gtm_pkg::GTM_CFG_WIDE;
      firstCtl <= '0;
      secondCtl <= '0;
      firstPwmOut <= 1'b0;
      firstAdcTrigger <= 1'b0;
      rtcCountOn <= 1'b0;
    end
    else
    begin
      widthConfig <= next_widthConfig;
      firstCtl <= next_firstCtl;
      secondCtl <= next_secondCtl;
      firstPwmOut <= next_pwm;
      firstAdcTrigger <= next_trig;
      rtcCountOn <= next_rtc;
    end
  end

  a_first_freeze: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (halted && controlReg[1] && controlReg[0]) |=> !firstCtl.advance) // [R7]
    else $error("first timer advances while frozen by halt");
  a_second_freeze: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (halted && controlReg[9] && controlReg[8]) |=> !secondCtl.advance) // [R6]
    else $error("second timer advances while frozen by halt");
  a_run_normal: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (!halted && controlReg[8]) |=> secondCtl.advance) // [R8]
    else $error("freeze bit acts while not halted");
  a_first_enable: assert property (@(posedge ref_clk) disable iff (!reset_n)
    1'b1 |=> firstCtl.run == $past(controlReg[0])) // [R10]
    else $error("first enable does not follow control bit 0");
  a_second_enable: assert property (@(posedge ref_clk) disable iff (!reset_n)
    1'b1 |=> secondCtl.run == $past(controlReg[8])) // [R9]
    else $error("second enable does not follow control bit 8");
  a_pwm_invert: assert property (@(posedge ref_clk) disable iff (!reset_n)
    1'b1 |=> firstPwmOut == ($past(firstPwmRaw) ^ $past(controlReg[6]))) // [R11]
    else $error("pwm output polarity wrong");
  a_trig_gate: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !controlReg[5] |=> !firstAdcTrigger) // [R12]
    else $error("adc trigger passes while gate is off");
  a_rtc_enable: assert property (@(posedge ref_clk) disable iff (!reset_n)
    1'b1 |=> rtcCountOn == $past(controlReg[4])) // [R14]
    else $error("rtc enable does not follow control bit 4");
  a_wide_mode: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (cfgReg[2:0] == 3'h0) |=> secondCtl.mode == $past(firstModeReg[1:0])) // [R3]
    else $error("wide config does not use first mode");
  a_split_mode: assert property (@(posedge ref_clk) disable iff (!reset_n)
    cfgReg[2] |=> secondCtl.mode == $past(secondModeReg[1:0])) // [R2]
    else $error("split config does not use second mode");
  a_edge_both: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (controlReg[11:10] == 2'b11) |=> secondCtl.riseEdge && secondCtl.fallEdge) // [R4]
    else $error("both-edge select wrong for second half");
  a_edge_fall: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (controlReg[3:2] == 2'b01) |=> !firstCtl.riseEdge && firstCtl.fallEdge) // [R5]
    else $error("falling-edge select wrong for first half");
endmodule

// *** gtm_timer_mode_control_tb.sv ***
// self-checking bench for the timer mode and control block
`timescale 1ns/10ps
module gtm_timer_mode_control_tb;
  logic ref_clk = 0, reset_n = 0;
  logic [11:0] awAddr = 0, arAddr = 0;
  logic [31:0] wData = 0, rData;
  logic [3:0] wStrb = 0;
  logic awValid = 0, wValid = 0, bReady = 0, arValid = 0, rReady = 0;
  logic awReady, wReady, bValid, arReady, rValid;
  logic [1:0] bResp, rResp;
  logic haltReq = 0, pwmReq = 0, trigReq = 0;
  logic debugHalt, firstPwmRaw, firstAdcTriggerRaw, rtcCountOn, firstPwmOut, firstAdcTrigger;
  gtm_pkg::gtm_half_t firstCtl, secondCtl;
  gtm_pkg::gtm_cfg_t widthConfig;
  int fails = 0, checkCount = 0, cycles = 0;
  logic [31:0] mreg [4];

  gtm_far_side i_gtm_far_side (.ref_clk(ref_clk), .reset_n(reset_n), .haltReq(haltReq),
    .pwmReq(pwmReq), .trigReq(trigReq), .debugHalt(debugHalt),
    .firstPwmRaw(firstPwmRaw), .firstAdcTriggerRaw(firstAdcTriggerRaw));

  gtm_timer_mode_control i_gtm_timer_mode_control (.ref_clk(ref_clk), .reset_n(reset_n),
    .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
    .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
    .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
    .debugHalt(debugHalt), .firstPwmRaw(firstPwmRaw), .firstAdcTriggerRaw(firstAdcTriggerRaw),
    .firstCtl(firstCtl), .secondCtl(secondCtl), .widthConfig(widthConfig),
    .rtcCountOn(rtcCountOn), .firstPwmOut(firstPwmOut), .firstAdcTrigger(firstAdcTrigger));

  always #5 ref_clk = ~ref_clk;

  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 8000)
    begin
      fails++;
      printVerdict();
    end
  end

  task printVerdict();
    $display("checks %0d mismatches %0d", checkCount, fails);
    if (fails == 0 && checkCount > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task chk32(input string what, input logic [31:0] exp, input logic [31:0] got);
    checkCount++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // ready is combinational: sample it at the falling edge before the taking edge
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
    output logic [1:0] r);
    logic ta, tw, gotA, gotW, b;
    gotA = 0;
    gotW = 0;
    @(posedge ref_clk);
    awAddr <= a;
    wData <= d;
    wStrb <= s;
    awValid <= 1;
    wValid <= 1;
    bReady <= 1;
    while (!(gotA && gotW))
    begin
      @(negedge ref_clk);
      ta = !gotA && awReady;
      tw = !gotW && wReady;
      @(posedge ref_clk);
      gotA |= ta;
      gotW |= tw;
      if (ta) awValid <= 0;
      if (tw) wValid <= 0;
    end
    do
    begin
      @(negedge ref_clk);
      b = bValid;
      r = bResp;
      @(posedge ref_clk);
    end while (!b);
    bReady <= 0;
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    logic t;
    @(posedge ref_clk);
    arAddr <= a;
    arValid <= 1;
    rReady <= 1;
    do
    begin
      @(negedge ref_clk);
      t = arReady;
      @(posedge ref_clk);
    end while (!t);
    arValid <= 0;
    do
    begin
      @(negedge ref_clk);
      t = rValid;
      d = rData;
      r = rResp;
      @(posedge ref_clk);
    end while (!t);
    rReady <= 0;
  endtask

  function automatic logic [31:0] mask(input logic [1:0] i);
    return i == 0 ? gtm_pkg::CONFIG_MASK : i == 3 ? gtm_pkg::CONTROL_MASK : gtm_pkg::MODE_MASK;
  endfunction

  task automatic wrChk(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [1:0] r;
    logic [31:0] bm;
    for (int k = 0; k < 4; k++) bm[k*8 +: 8] = {8{s[k]}};
    wr(a, d, s, r);
    if (a < 12'h010) mreg[a[3:2]] = ((mreg[a[3:2]] & ~bm) | (d & bm)) & mask(a[3:2]);
    chk32("bresp", a < 12'h010 ? gtm_pkg::RESP_OKAY : gtm_pkg::RESP_SLVERR, r);
  endtask

  task automatic rdChk(input logic [11:0] a);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk32("rdata", a < 12'h010 ? mreg[a[3:2]] : 32'h0000_0000, d);
    chk32("rresp", a < 12'h010 ? gtm_pkg::RESP_OKAY : gtm_pkg::RESP_SLVERR, r);
  endtask

  function automatic gtm_pkg::gtm_half_t half(logic [3:0] m, logic on, logic frz, logic [1:0] e);
    gtm_pkg::gtm_half_t h;
    h.run = on;
    h.advance = on && !(haltReq && frz);
    h.mode = gtm_pkg::gtm_mode_t'(m[1:0]);
    h.edgeTime = m[2];
    h.pwmSelect = m[3];
    h.riseEdge = e == 0 || e == 3;
    h.fallEdge = e == 1 || e == 3;
    return h;
  endfunction

  task automatic chkOut();
    logic [31:0] c, m2;
    logic [1:0] wc;
    gtm_pkg::gtm_half_t h2;
    // look at registered outputs away from the edge that launches them
    @(negedge ref_clk);
    c = mreg[3];
    m2 = mreg[0][2] ? mreg[2] : mreg[1];
    wc = mreg[0][2] ? 2'h2 : mreg[0][1] ? 2'h3 : mreg[0][1:0];
    h2 = half(m2[3:0], c[8], c[9], c[11:10]);
    chk32("firstCtl", half(mreg[1][3:0], c[0], c[1], c[3:2]), firstCtl);
    chk32("secondCtl", h2, secondCtl);
    chk32("widthConfig", wc, widthConfig);
    chk32("rtcCountOn", c[4], rtcCountOn);
    chk32("firstPwmOut", pwmReq ^ c[6], firstPwmOut);
    chk32("firstAdcTrigger", trigReq & c[5], firstAdcTrigger);
  endtask

  initial
  begin
    logic [31:0] d;
    void'($urandom(32'h0000_fb46));
    for (int i = 0; i < 4; i++) mreg[i] = 0;
    repeat (5) @(posedge ref_clk);
    reset_n <= 1;
    repeat (4) @(posedge ref_clk);
    chkOut();
    for (int i = 0; i < 5; i++) rdChk(12'(i * 4));
    $display("test reset values done");
    for (int i = 0; i < 16; i++)
    begin
      d = ($urandom % 6) * 4;
      wrChk(d[11:0], $urandom, 4'($urandom));
      rdChk(d[11:0]);
    end
    $display("test register access done");
    for (int i = 0; i < 32; i++)
    begin
      d = $urandom;
      d[3:2] = i[1:0];
      d[11:10] = i[3:2];
      wrChk(gtm_pkg::ADDR_CONFIG, {29'h0000_0000, i[2:0]}, 4'hf);
      wrChk(gtm_pkg::ADDR_FIRST_MODE, $urandom, 4'hf);
      wrChk(gtm_pkg::ADDR_SECOND_MODE, $urandom, 4'hf);
      wrChk(gtm_pkg::ADDR_CONTROL, d, 4'hf);
      haltReq <= i[4];
      pwmReq <= $urandom;
      trigReq <= $urandom;
      repeat (6) @(posedge ref_clk);
      chkOut();
    end
    $display("test decode sweep done");
    reset_n <= 0;
    repeat (2) @(posedge ref_clk);
    reset_n <= 1;
    for (int i = 0; i < 4; i++) mreg[i] = 0;
    repeat (4) @(posedge ref_clk);
    chkOut();
    rdChk(gtm_pkg::ADDR_CONTROL);
    $display("test second reset done");
    printVerdict();
  end
endmodule
